/* src/slr_speed_regulator.sv */
`timescale 1ns/10ps
`default_nettype none
module slr_speed_regulator
  import slr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire slr_ctrl_t ctrl_method,
  input wire logic torque_mode,
  input wire logic motor2_sel,
  input wire logic third_set_for_motor1,
  input wire logic signed [`SLR_SPD_W-1:0] freq_cmd,
  input wire logic signed [`SLR_SPD_W-1:0] freq_fbk,
  input wire slr_gain_t low_set,
  input wire slr_gain_t high_set,
  input wire slr_gain_t third_set,
  input wire logic [`SLR_TCODE_W-1:0] low_filter_code,
  input wire logic [`SLR_TCODE_W-1:0] high_filter_code,
  input wire logic [`SLR_FREQ_W-1:0] sw_freq1,
  input wire logic [`SLR_FREQ_W-1:0] sw_freq2,
  input wire logic [`SLR_FREQ_W-1:0] sw_freq3,
  input wire logic deriv_en,
  input wire logic [`SLR_KD_W-1:0] deriv_gain,
  input wire slr_tsrc_t drive_src,
  input wire slr_tsrc_t brake_src,
  input wire slr_lim_src_t lim_src,
  input wire slr_dev_cfg_t dev_cfg,
  input wire logic fault_clear,
  output logic signed [`SLR_TQ_W-1:0] torque_current_ref,
  output logic [`SLR_TQ_W-1:0] drive_limit,
  output logic [`SLR_TQ_W-1:0] brake_limit,
  output logic regulator_active,
  output logic large_speed_deviation,
  output logic decel_stop_req,
  output logic coast_stop_req,
  output logic [`SLR_FC_W-1:0] deviation_fault_code
);
  localparam int LOOP_CYCLES = `SLR_LOOP_CYCLES;
  localparam int DEV_UNIT = `SLR_DEV_SAMPLES_PER_UNIT;
  localparam int LOOP_US = `SLR_LOOP_PERIOD_US;
  localparam int AW = 48; // wide arithmetic width
  localparam int IW = 32; // integrator width incl. fraction

  // sample tick divider
  logic [15:0] tick_cnt_r;
  logic [15:0] tick_cnt_nxt;
  logic tick; // one-cycle loop sample strobe

  always_comb begin
    tick = (tick_cnt_r == 16'(LOOP_CYCLES - 1));
    tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // torque limit from one source, clamped to 0..300 %
  function automatic logic [`SLR_TQ_W-1:0] lim_of(input slr_tsrc_t sel, input logic [`SLR_TQ_W-1:0] dig,
                                                  input slr_lim_src_t s);
    logic signed [AW-1:0] v;
    v = '0;
    unique case (sel)
      SLR_SRC_DIGITAL: v = AW'($signed({1'b0, dig}));
      SLR_SRC_ANALOG: v = AW'(s.analog_input_channel) * `SLR_TORQUE_MAX / `SLR_AI_FULL_SCALE;
      SLR_SRC_PULSE: begin
        // only the sixth input in a limit function carries the pulse
        if (s.sixth_digital_input_fn == `SLR_X6_FN_LIMIT_A || s.sixth_digital_input_fn == `SLR_X6_FN_LIMIT_B) begin
          v = AW'($signed({1'b0, s.pulse_hz})) * `SLR_TORQUE_MAX / `SLR_PULSE_FULL_HZ;
        end
      end
      SLR_SRC_LOOP: v = AW'(s.closed_loop);
    endcase
    if (v < 0) begin
      v = '0;
    end else if (v > `SLR_TORQUE_MAX) begin
      v = AW'(`SLR_TORQUE_MAX);
    end
    return v[`SLR_TQ_W-1:0];
  endfunction

  // running frequency and gain scheduling
  logic [`SLR_SPD_W-1:0] run_freq; // magnitude of feedback speed
  logic [`SLR_SPD_W-1:0] sw1_x, sw2_x, sw3_x; // switch points widened
  logic [`SLR_KP_W-1:0] kp_blend;
  logic [`SLR_TI_W-1:0] ti_blend;
  slr_gain_t gain; // gain pair in use this sample
  logic [`SLR_TCODE_W-1:0] tc_sel; // filter code in use

  always_comb begin
    run_freq = freq_fbk[`SLR_SPD_W-1] ? `SLR_SPD_W'(-freq_fbk) : `SLR_SPD_W'(freq_fbk);
    sw1_x = `SLR_SPD_W'(sw_freq1);
    sw2_x = `SLR_SPD_W'(sw_freq2);
    sw3_x = `SLR_SPD_W'(sw_freq3);
    if (motor2_sel) begin
      // second motor: third set below the third point, else the first motor's high-speed pair
      gain = (run_freq < sw3_x) ? third_set : high_set;
    end else if (third_set_for_motor1 && run_freq > sw3_x) begin
      gain = third_set;
    end else begin
      gain.kp = kp_blend;
      gain.ti = ti_blend;
    end
    // low filter only in the pure low-speed band
    tc_sel = (run_freq < sw1_x) ? low_filter_code : high_filter_code;
  end

  slr_interp #(.VW(`SLR_KP_W), .FW(`SLR_SPD_W)) u_kp_interp (
    .run_freq(run_freq),
    .sw_lo(sw1_x),
    .sw_hi(sw2_x),
    .val_lo(low_set.kp),
    .val_hi(high_set.kp),
    .val_out(kp_blend)
  );

  slr_interp #(.VW(`SLR_TI_W), .FW(`SLR_SPD_W)) u_ti_interp (
    .run_freq(run_freq),
    .sw_lo(sw1_x),
    .sw_hi(sw2_x),
    .val_lo(low_set.ti),
    .val_hi(high_set.ti),
    .val_out(ti_blend)
  );

  // regulator core state
  logic signed [IW-1:0] integ_r, integ_nxt; // integral with fraction
  logic signed [`SLR_SPD_W:0] err_prev_r, err_prev_nxt; // for derivative
  logic [`SLR_TQ_W-1:0] drv_lim_r, drv_lim_nxt;
  logic [`SLR_TQ_W-1:0] brk_lim_r, brk_lim_nxt;
  logic signed [`SLR_TQ_W-1:0] sat_r, sat_nxt; // saturated output
  logic active_r, active_nxt;
  logic signed [`SLR_TQ_W-1:0] ref_r;
  logic signed [`SLR_TQ_W-1:0] filt_y;
  logic active; // regulator allowed to run
  logic signed [`SLR_SPD_W:0] err;
  logic signed [AW-1:0] prop, incr, deriv, raw, kp_s;
  logic sat_hi, sat_lo;

  always_comb begin
    // scheduled gains only in the two closed-speed methods, speed mode only
    active = (ctrl_method == SLR_CTRL_VECTOR || ctrl_method == SLR_CTRL_ENC_VPH) && !torque_mode;
    err = (`SLR_SPD_W+1)'(freq_cmd) - (`SLR_SPD_W+1)'(freq_fbk);
    kp_s = AW'($signed({1'b0, gain.kp}));
    prop = AW'(err) * kp_s / `SLR_KP_DIV;
    incr = '0;
    if (gain.ti != '0) begin
      // per-sample share of kp*err over the integral time
      incr = ((AW'(err) * kp_s * LOOP_US) <<< `SLR_INT_FRAC) /
             (AW'($signed({1'b0, gain.ti})) * `SLR_KP_DIV * `SLR_MS_PER_S_US);
    end
    deriv = '0;
    if (deriv_en) begin
      deriv = AW'(err - err_prev_r) * AW'($signed({1'b0, deriv_gain})) / `SLR_KD_DIV;
    end
    raw = prop + (AW'(integ_r) >>> `SLR_INT_FRAC) + deriv;
    drv_lim_nxt = lim_of(drive_src, lim_src.drive_digital, lim_src);
    brk_lim_nxt = lim_of(brake_src, lim_src.brake_digital, lim_src);
    sat_hi = raw > AW'($signed({1'b0, drv_lim_r}));
    sat_lo = raw < -AW'($signed({1'b0, brk_lim_r}));
    integ_nxt = integ_r;
    err_prev_nxt = err_prev_r;
    sat_nxt = sat_r;
    active_nxt = active;
    if (!active) begin
      // drop all memory so a re-entry starts clean
      integ_nxt = '0;
      err_prev_nxt = '0;
      sat_nxt = '0;
    end else if (tick) begin
      err_prev_nxt = err;
      if (sat_hi) begin
        sat_nxt = `SLR_TQ_W'(drv_lim_r);
      end else if (sat_lo) begin
        sat_nxt = -`SLR_TQ_W'(brk_lim_r);
      end else begin
        sat_nxt = `SLR_TQ_W'(raw);
      end
      if (gain.ti == '0) begin
        integ_nxt = '0;
      end else if (!((sat_hi && incr > 0) || (sat_lo && incr < 0))) begin
        // stop winding further into the limit
        integ_nxt = integ_r + IW'(incr);
      end
    end
  end

  // regulator registers
  always_ff @(posedge clock) begin
    if (srst) begin
      integ_r <= '0;
      err_prev_r <= '0;
      drv_lim_r <= '0;
      brk_lim_r <= '0;
      sat_r <= '0;
      active_r <= 1'b0;
      ref_r <= '0;
    end else begin
      integ_r <= integ_nxt;
      err_prev_r <= err_prev_nxt;
      drv_lim_r <= drv_lim_nxt;
      brk_lim_r <= brk_lim_nxt;
      sat_r <= sat_nxt;
      active_r <= active_nxt;
      ref_r <= active ? filt_y : '0;
    end
  end

  // output lag filter, stepped one cycle after the sample
  logic tick_d_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick;
    end
  end

  slr_lag_filter #(.W(`SLR_TQ_W)) u_out_filter (
    .clock(clock),
    .srst(srst),
    .clear(!active),
    .strobe(tick_d_r),
    .tc_code(tc_sel),
    .x(sat_r),
    .y(filt_y)
  );

  // large speed deviation watch
  logic [15:0] dev_cnt_r, dev_cnt_nxt; // consecutive samples over threshold
  logic dev_r, dev_nxt;
  logic decel_r, decel_nxt;
  logic coast_r, coast_nxt;
  logic [`SLR_FC_W-1:0] fcode_r, fcode_nxt;
  logic [`SLR_SPD_W:0] err_mag;
  logic [15:0] dev_limit; // detection time in samples
  logic dev_set;

  always_comb begin
    err_mag = err[`SLR_SPD_W] ? (`SLR_SPD_W+1)'(-err) : (`SLR_SPD_W+1)'(err);
    dev_limit = 16'(32'(dev_cfg.time_tenths) * DEV_UNIT);
    dev_cnt_nxt = dev_cnt_r;
    dev_set = 1'b0;
    if (torque_mode) begin
      dev_cnt_nxt = 16'h0000;
    end else if (tick) begin
      // threshold shares the speed scale, 100 % = maximum frequency
      if (err_mag > (`SLR_SPD_W+1)'(dev_cfg.threshold)) begin
        if (dev_cnt_r != 16'hFFFF) begin
          dev_cnt_nxt = dev_cnt_r + 16'h0001;
        end
        dev_set = (dev_cnt_r >= dev_limit);
      end else begin
        dev_cnt_nxt = 16'h0000;
      end
    end
    // a new detection wins over a clear in the same cycle
    dev_nxt = dev_set ? 1'b1 : (fault_clear ? 1'b0 : dev_r);
    decel_nxt = dev_nxt && dev_cfg.response == SLR_DEV_DECEL;
    coast_nxt = dev_nxt && dev_cfg.response == SLR_DEV_COAST;
    fcode_nxt = coast_nxt ? `SLR_DEV_FAULT_CODE : '0;
  end

  // deviation registers
  always_ff @(posedge clock) begin
    if (srst) begin
      dev_cnt_r <= 16'h0000;
      dev_r <= 1'b0;
      decel_r <= 1'b0;
      coast_r <= 1'b0;
      fcode_r <= '0;
    end else begin
      dev_cnt_r <= dev_cnt_nxt;
      dev_r <= dev_nxt;
      decel_r <= decel_nxt;
      coast_r <= coast_nxt;
      fcode_r <= fcode_nxt;
    end
  end

  assign torque_current_ref = ref_r;
  assign drive_limit = drv_lim_r;
  assign brake_limit = brk_lim_r;
  assign regulator_active = active_r;
  assign large_speed_deviation = dev_r;
  assign decel_stop_req = decel_r;
  assign coast_stop_req = coast_r;
  assign deviation_fault_code = fcode_r;
endmodule
`default_nettype wire

/* src/slr_defines.svh */
// Functional notes
// - below first switch point use low-speed gains
// - above second switch point use high-speed gains
// - between switch points interpolate gains linearly
// - gain 0.1..200.0, integral 0..10 s ranges
// - zero integral time means proportional only
// - first-order lag filter, per-set code 0..8
// - second motor: third set below third point
// - first motor may use third set above
// - gains act only vector or encoder mode
// - optional derivative term, gain 0.00..10.00
// - limit source: digital, analog, pulse, closed loop
// - analog full scale equals 300% torque
// - 100 kHz pulse equals 300% torque
// - pulse limit only sixth input, code 51/52
// - negative torque limit clamps to zero
// - digital limits 0..300%, defaults 180/150%
// - deviation response: decelerate, coast+fault, continue
// - flag deviation above threshold beyond detection time
// - deviation threshold scaled to maximum frequency
// - deviation detection only in speed mode
// - speed mode runs regulator within torque limits
`ifndef SLR_DEFINES_SVH
`define SLR_DEFINES_SVH
// clock and loop sampling
`define SLR_CLK_PERIOD_NS 100
`define SLR_LOOP_PERIOD_US 250
`define SLR_LOOP_CYCLES (`SLR_LOOP_PERIOD_US * 1000 / `SLR_CLK_PERIOD_NS)
`define SLR_DEV_TIME_UNIT_US 100000
`define SLR_DEV_SAMPLES_PER_UNIT (`SLR_DEV_TIME_UNIT_US / `SLR_LOOP_PERIOD_US)
// field widths
`define SLR_SPD_W 16
`define SLR_FREQ_W 11
`define SLR_KP_W 11
`define SLR_TI_W 14
`define SLR_KD_W 10
`define SLR_TQ_W 16
`define SLR_AI_W 13
`define SLR_PULSE_W 17
`define SLR_FC_W 8
`define SLR_TCODE_W 4
`define SLR_DEV_TIME_W 7
// scaling: speeds and torques in 0.1 %, kp in 0.1, kd in 0.01, ti in ms
`define SLR_KP_DIV 10
`define SLR_KD_DIV 100
`define SLR_MS_PER_S_US 1000
`define SLR_INT_FRAC 8
`define SLR_FILT_FRAC 8
`define SLR_TCODE_MAX 4'h8
`define SLR_TORQUE_MAX 3000
`define SLR_AI_FULL_SCALE 4095
`define SLR_PULSE_FULL_HZ 100000
`define SLR_X6_FN_LIMIT_A 8'h33
`define SLR_X6_FN_LIMIT_B 8'h34
// arbitrary fault code value shown on a coast-stop deviation
`define SLR_DEV_FAULT_CODE 8'h1D
// documented power-up settings, for whoever drives the setting ports
`define SLR_DEF_KP_LOW 11'h0C8
`define SLR_DEF_TI_LOW 14'h00C8
`define SLR_DEF_KP_HIGH 11'h064
`define SLR_DEF_TI_HIGH 14'h0258
`define SLR_DEF_SW1 11'h064
`define SLR_DEF_SW2 11'h0C8
`define SLR_DEF_SW3 11'h320
`define SLR_DEF_LIM_P 16'h0708
`define SLR_DEF_LIM_G 16'h05DC
`define SLR_DEF_DEV_THR 11'h0C8
`define SLR_DEF_DEV_TIME 7'h64
`endif

/* src/slr_pkg.sv */
`include "slr_defines.svh"
package slr_pkg;
  // torque limit source selector
  typedef enum logic [1:0] {
    SLR_SRC_DIGITAL = 2'b00,
    SLR_SRC_ANALOG = 2'b01,
    SLR_SRC_PULSE = 2'b10,
    SLR_SRC_LOOP = 2'b11
  } slr_tsrc_t;
  // reaction to a large speed deviation; code 3 behaves as continue
  typedef enum logic [1:0] {
    SLR_DEV_DECEL = 2'b00,
    SLR_DEV_COAST = 2'b01,
    SLR_DEV_CONTINUE = 2'b10,
    SLR_DEV_SPARE = 2'b11
  } slr_dev_resp_t;
  // motor control method
  typedef enum logic [1:0] {
    SLR_CTRL_VF = 2'b00,
    SLR_CTRL_VECTOR = 2'b01,
    SLR_CTRL_ENC_VPH = 2'b10,
    SLR_CTRL_SPARE = 2'b11
  } slr_ctrl_t;
  // one proportional/integral pair
  typedef struct packed {
    logic [`SLR_KP_W-1:0] kp;
    logic [`SLR_TI_W-1:0] ti;
  } slr_gain_t;
  // raw torque limit sources
  typedef struct packed {
    logic [`SLR_TQ_W-1:0] drive_digital;
    logic [`SLR_TQ_W-1:0] brake_digital;
    logic signed [`SLR_AI_W-1:0] analog_input_channel;
    logic [`SLR_PULSE_W-1:0] pulse_hz;
    logic [`SLR_FC_W-1:0] sixth_digital_input_fn;
    logic signed [`SLR_TQ_W-1:0] closed_loop;
  } slr_lim_src_t;
  // deviation watch settings
  typedef struct packed {
    logic [`SLR_FREQ_W-1:0] threshold;
    logic [`SLR_DEV_TIME_W-1:0] time_tenths;
    slr_dev_resp_t response;
  } slr_dev_cfg_t;
endpackage

/* src/slr_interp.sv */
`timescale 1ns/10ps
`default_nettype none
module slr_interp
  import slr_pkg::*;
#(
  parameter int VW = 14,
  parameter int FW = 16
) (
  input wire logic [FW-1:0] run_freq,
  input wire logic [FW-1:0] sw_lo,
  input wire logic [FW-1:0] sw_hi,
  input wire logic [VW-1:0] val_lo,
  input wire logic [VW-1:0] val_hi,
  output logic [VW-1:0] val_out
);
  localparam int PW = VW + FW + 2;
  logic signed [PW-1:0] diff; // high minus low value
  logic signed [PW-1:0] num; // diff scaled by position in band
  logic signed [PW-1:0] den; // band width
  // pick or blend between the two settings by running frequency
  always_comb begin
    diff = PW'($signed({1'b0, val_hi})) - PW'($signed({1'b0, val_lo}));
    num = diff * PW'($signed({1'b0, run_freq - sw_lo}));
    den = PW'($signed({1'b0, sw_hi - sw_lo}));
    if (run_freq < sw_lo) begin
      val_out = val_lo;
    end else if (run_freq >= sw_hi || sw_hi <= sw_lo) begin
      val_out = val_hi;
    end else begin
      // den is nonzero here, the degenerate band was caught above
      val_out = VW'(PW'($signed({1'b0, val_lo})) + num / den);
    end
  end
endmodule
`default_nettype wire

/* src/slr_lag_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module slr_lag_filter
  import slr_pkg::*;
#(
  parameter int W = 16,
  parameter int FRAC = `SLR_FILT_FRAC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clear,
  input wire logic strobe,
  input wire logic [`SLR_TCODE_W-1:0] tc_code,
  input wire logic signed [W-1:0] x,
  output logic signed [W-1:0] y
);
  logic signed [W+FRAC-1:0] acc_r; // filter state with fraction bits
  logic signed [W+FRAC-1:0] acc_nxt;
  logic signed [W+FRAC-1:0] x_ext; // input aligned to state
  logic [`SLR_TCODE_W-1:0] code; // code held to its legal range
  // first-order lag as a shift, so no multiplier is spent per set
  always_comb begin
    x_ext = (W+FRAC)'(x) <<< FRAC;
    code = (tc_code > `SLR_TCODE_MAX) ? `SLR_TCODE_MAX : tc_code;
    acc_nxt = acc_r;
    if (clear) begin
      acc_nxt = '0;
    end else if (strobe) begin
      acc_nxt = acc_r + ((x_ext - acc_r) >>> code);
    end
  end
  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end
  assign y = acc_r[W+FRAC-1:FRAC];
endmodule
`default_nettype wire

/* testbench/slr_speed_regulator_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slr_defines.svh"
module slr_speed_regulator_sva
  import slr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire slr_ctrl_t ctrl_method,
  input wire logic torque_mode,
  input wire slr_tsrc_t drive_src,
  input wire slr_tsrc_t brake_src,
  input wire slr_lim_src_t lim_src,
  input wire logic fault_clear,
  input wire logic signed [`SLR_TQ_W-1:0] torque_current_ref,
  input wire logic [`SLR_TQ_W-1:0] drive_limit,
  input wire logic [`SLR_TQ_W-1:0] brake_limit,
  input wire logic large_speed_deviation,
  input wire logic decel_stop_req,
  input wire logic coast_stop_req,
  input wire logic [`SLR_FC_W-1:0] deviation_fault_code
);
  // one domain, so clock and reset are set once
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // limits: first cycle after reset is skipped, outputs still zero there
  a_digital_pass: assert property (
    !$past(srst) && drive_src == SLR_SRC_DIGITAL && lim_src.drive_digital <= 16'h0BB8
    |=> drive_limit == $past(lim_src.drive_digital)) else $error("digital limit not passed");
  a_limit_ceiling: assert property (
    drive_limit <= 16'h0BB8 && brake_limit <= 16'h0BB8) else $error("limit above ceiling");
  a_analog_full: assert property (
    !$past(srst) && drive_src == SLR_SRC_ANALOG && lim_src.analog_input_channel == 13'h0FFF
    |=> drive_limit == 16'h0BB8) else $error("analog full scale wrong");
  a_pulse_refuse: assert property (
    !$past(srst) && drive_src == SLR_SRC_PULSE && lim_src.sixth_digital_input_fn != 8'h33
    && lim_src.sixth_digital_input_fn != 8'h34 |=> drive_limit == 16'h0000) else $error("pulse limit accepted");
  a_pulse_full: assert property (
    !$past(srst) && drive_src == SLR_SRC_PULSE && lim_src.pulse_hz == 17'h186A0
    && (lim_src.sixth_digital_input_fn == 8'h33 || lim_src.sixth_digital_input_fn == 8'h34)
    |=> drive_limit == 16'h0BB8) else $error("pulse full scale wrong");
  a_neg_clamp: assert property (
    !$past(srst) && brake_src == SLR_SRC_LOOP && lim_src.closed_loop[15]
    |=> brake_limit == 16'h0000) else $error("negative limit not clamped");
  // regulator off: ref must be zero once the mode has settled
  a_torque_zero: assert property (
    torque_mode [*3] |-> torque_current_ref == 16'sh0000) else $error("ref live in torque mode");
  a_method_zero: assert property (
    (ctrl_method == SLR_CTRL_VF || ctrl_method == SLR_CTRL_SPARE) [*3]
    |-> torque_current_ref == 16'sh0000) else $error("ref live in plain mode");
  // deviation flag and its reactions
  a_flag_sticky: assert property (
    large_speed_deviation && !fault_clear |=> large_speed_deviation) else $error("flag dropped");
  a_coast_code: assert property (
    coast_stop_req |-> large_speed_deviation && deviation_fault_code == `SLR_DEV_FAULT_CODE)
    else $error("coast without code");
  a_decel_only: assert property (
    decel_stop_req |-> large_speed_deviation && !coast_stop_req && deviation_fault_code == 8'h00)
    else $error("decel mixed with coast");
  a_no_dev_torque: assert property (
    torque_mode ##1 torque_mode |-> !$rose(large_speed_deviation)) else $error("deviation in torque mode");
  c_dev_flag: cover property ($rose(large_speed_deviation));
  c_coast: cover property (coast_stop_req);
  c_decel: cover property (decel_stop_req);
  c_drive_sat: cover property (drive_limit != 16'h0000 && torque_current_ref == $signed(drive_limit));
endmodule
bind slr_speed_regulator slr_speed_regulator_sva u_sva (
  .clock, .srst, .ctrl_method, .torque_mode, .drive_src, .brake_src, .lim_src, .fault_clear, .torque_current_ref,
  .drive_limit, .brake_limit, .large_speed_deviation, .decel_stop_req, .coast_stop_req, .deviation_fault_code
);
`default_nettype wire

/* testbench/slr_motor_model.sv */
`timescale 1ns/10ps
`default_nettype none
module slr_motor_model
  import slr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic signed [15:0] target,
  input wire logic [15:0] rate,
  output logic signed [15:0] freq_fbk
);
  logic signed [15:0] fbk_r, fbk_nxt; // follower speed and its next value
  logic signed [16:0] gap; // one bit wider so the gap never wraps
  // speed follows the target at rate per clock; a plain follower rather
  // than a torque-driven plant, traded for exact control of the error
  always_comb begin
    gap = target - fbk_r;
    fbk_nxt = target;
    if (gap > $signed({1'b0, rate})) begin // slow rise
      fbk_nxt = fbk_r + rate;
    end else if (gap < -$signed({1'b0, rate})) begin // slow fall
      fbk_nxt = fbk_r - rate;
    end
  end
  // register only
  always_ff @(posedge clock) begin
    fbk_r <= srst ? 16'sh0000 : fbk_nxt;
  end
  assign freq_fbk = fbk_r;
endmodule
`default_nettype wire

/* testbench/test_speed_loop_regulator.sv */
`timescale 1ns/10ps
`default_nettype none
`include "slr_defines.svh"
module test_speed_loop_regulator
  import slr_pkg::*;
;
  typedef struct {int id; logic [15:0] val; int due;} slr_note_t;
  slr_note_t notes[$]; // expected results, oldest first
  logic clock, srst, torque_mode, motor2_sel, third_set_for_motor1, deriv_en, fault_clear;
  slr_ctrl_t ctrl_method;
  logic signed [15:0] freq_cmd, freq_fbk, fbk_target, torque_current_ref;
  logic [15:0] fbk_rate, drive_limit, brake_limit;
  slr_gain_t low_set, high_set, third_set;
  logic [3:0] low_filter_code, high_filter_code;
  logic [10:0] sw_freq1, sw_freq2, sw_freq3;
  logic [9:0] deriv_gain;
  slr_tsrc_t drive_src, brake_src;
  slr_lim_src_t lim_src;
  slr_dev_cfg_t dev_cfg;
  logic regulator_active, large_speed_deviation, decel_stop_req, coast_stop_req;
  logic [7:0] deviation_fault_code;
  int fails, samples_checked, cyc, seed;
  slr_speed_regulator DUT (.clock, .srst, .ctrl_method, .torque_mode, .motor2_sel, .third_set_for_motor1,
    .freq_cmd, .freq_fbk, .low_set, .high_set, .third_set, .low_filter_code, .high_filter_code,
    .sw_freq1, .sw_freq2, .sw_freq3, .deriv_en, .deriv_gain, .drive_src, .brake_src, .lim_src,
    .dev_cfg, .fault_clear, .torque_current_ref, .drive_limit, .brake_limit, .regulator_active,
    .large_speed_deviation, .decel_stop_req, .coast_stop_req, .deviation_fault_code);
  // far side: torque loop and motor, speed fed back
  slr_motor_model u_motor (.clock, .srst, .target(fbk_target), .rate(fbk_rate), .freq_fbk);
  always #50 clock = ~clock;
  // cycle count doubles as the hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc >= 90000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", nm, e, s);
    end
  endtask
  // note due lat rising edges from now
  task automatic note_exp(input int id, input logic [15:0] v, input int lat);
    notes.push_back('{id, v, cyc + lat});
  endtask
  // watcher: oldest note is compared once its result is due
  always @(negedge clock) begin
    slr_note_t n;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      case (n.id)
        0: chk_val("drive_limit", n.val, drive_limit);
        1: chk_val("brake_limit", n.val, brake_limit);
        2: chk_val("torque_current_ref", n.val, torque_current_ref);
        3: chk_flag("large_speed_deviation", n.val[0], large_speed_deviation);
        4: chk_flag("decel_stop_req", n.val[0], decel_stop_req);
        5: chk_flag("coast_stop_req", n.val[0], coast_stop_req);
        6: chk_val("deviation_fault_code", n.val, {8'h00, deviation_fault_code});
        8: chk_flag("regulator_active", n.val[0], regulator_active);
        default: chk_flag("ref_at_drive_limit", n.val[0], torque_current_ref === $signed(drive_limit));
      endcase
    end
  end
  // wait n loop samples plus the filter and output stages
  task automatic run_ticks(input int n);
    repeat (n * `SLR_LOOP_CYCLES + 3) @(negedge clock);
  endtask
  // both limits from one source, drive and brake alike
  task automatic lim_case(input slr_tsrc_t s, input logic [15:0] d, input logic [12:0] a,
                          input logic [16:0] p, input logic [7:0] fn, input logic [15:0] lp, input logic [15:0] e);
    drive_src = s;
    brake_src = s;
    lim_src = '{d, d, a, p, fn, lp};
    note_exp(0, e, 1);
    note_exp(1, e, 1);
    repeat (2) @(negedge clock);
  endtask
  // settle speed and error, then note the expected output
  task automatic reg_case(input slr_ctrl_t m, input logic m2, t3, tq, input logic signed [15:0] fbk, err,
                          input int id, input logic [15:0] v);
    ctrl_method = m;
    motor2_sel = m2;
    third_set_for_motor1 = t3;
    torque_mode = tq;
    fbk_target = fbk;
    freq_cmd = fbk + err;
    deriv_gain = 10'($unsigned($random(seed)) % 1001);
    run_ticks(2);
    note_exp(id, v, 0);
    note_exp(8, {15'h0000, (m == SLR_CTRL_VECTOR || m == SLR_CTRL_ENC_VPH) && !tq}, 0);
  endtask
  // clear at zero error, then open a gap of 30 %
  task automatic dev_case(input slr_dev_resp_t r, input logic tq, input logic f);
    dev_cfg.response = r;
    torque_mode = tq;
    freq_cmd = fbk_target;
    fault_clear = 1'b1;
    repeat (3) @(negedge clock);
    fault_clear = 1'b0;
    freq_cmd = fbk_target + 16'sh012C;
    run_ticks(2);
    note_exp(3, {15'h0000, f}, 0);
    note_exp(4, {15'h0000, f && r == SLR_DEV_DECEL}, 0);
    note_exp(5, {15'h0000, f && r == SLR_DEV_COAST}, 0);
    note_exp(6, (f && r == SLR_DEV_COAST) ? 16'(`SLR_DEV_FAULT_CODE) : 16'h0000, 0);
  endtask
  initial begin
    logic [15:0] rnd;
    seed = 41;
    cyc = 0;
    clock = 1'b0;
    srst = 1'b1;
    {torque_mode, motor2_sel, third_set_for_motor1, fault_clear} = 4'h0;
    deriv_en = 1'b1;
    ctrl_method = SLR_CTRL_VECTOR;
    freq_cmd = 16'sh0000;
    fbk_target = 16'sh0000;
    fbk_rate = 16'h7FFF;
    low_set = '{11'h7D0, 14'h00C8}; // strong gain, default integral time
    high_set = '{11'h001, 14'h0000}; // weak gain, no integral
    third_set = '{11'h7D0, 14'h0000};
    low_filter_code = 4'h0;
    high_filter_code = 4'h0;
    {sw_freq1, sw_freq2, sw_freq3} = {11'h064, 11'h0C8, 11'h320};
    deriv_gain = 10'h000;
    drive_src = SLR_SRC_DIGITAL;
    brake_src = SLR_SRC_DIGITAL;
    lim_src = '0;
    dev_cfg = '{11'h0C8, 7'h00, SLR_DEV_CONTINUE}; // zero detection time keeps the run short
    repeat (3) @(negedge clock);
    srst = 1'b0;
    repeat (2) @(negedge clock);
    rnd = 16'($unsigned($random(seed)) % 3001);
    lim_case(SLR_SRC_DIGITAL, rnd, 13'h0000, 17'h00000, 8'h00, 16'h0000, rnd);
    lim_case(SLR_SRC_DIGITAL, 16'h0DAC, 13'h0000, 17'h00000, 8'h00, 16'h0000, 16'h0BB8);
    lim_case(SLR_SRC_ANALOG, 16'h0000, 13'h0FFF, 17'h00000, 8'h00, 16'h0000, 16'h0BB8);
    lim_case(SLR_SRC_ANALOG, 16'h0000, 13'h1F9C, 17'h00000, 8'h00, 16'h0000, 16'h0000);
    lim_case(SLR_SRC_PULSE, 16'h0000, 13'h0000, 17'h186A0, 8'h33, 16'h0000, 16'h0BB8);
    lim_case(SLR_SRC_PULSE, 16'h0000, 13'h0000, 17'h186A0, 8'h34, 16'h0000, 16'h0BB8);
    lim_case(SLR_SRC_PULSE, 16'h0000, 13'h0000, 17'h186A0, 8'h35, 16'h0000, 16'h0000);
    lim_case(SLR_SRC_LOOP, 16'h0000, 13'h0000, 17'h00000, 8'h00, 16'h04D2, 16'h04D2);
    lim_case(SLR_SRC_LOOP, 16'h0000, 13'h0000, 17'h00000, 8'h00, 16'hFFFB, 16'h0000);
    lim_case(SLR_SRC_DIGITAL, 16'h012C, 13'h0000, 17'h00000, 8'h00, 16'h0000, 16'h012C);
    $display("test limits done");
    for (int i = 0; i < 4; i++) begin
      reg_case(slr_ctrl_t'(i), 0, 0, 0, 16'sh0032, 16'sh0032, 2, (i[0] ^ i[1]) ? 16'h012C : 16'h0000);
    end
    $display("test methods done");
    reg_case(SLR_CTRL_VECTOR, 0, 0, 0, 16'sh01F4, 16'sh0032, 7, 16'h0000);
    reg_case(SLR_CTRL_VECTOR, 1, 0, 0, 16'sh01F4, 16'sh0032, 7, 16'h0001);
    reg_case(SLR_CTRL_VECTOR, 1, 0, 0, 16'sh0384, 16'sh0032, 7, 16'h0000);
    reg_case(SLR_CTRL_ENC_VPH, 0, 1, 0, 16'sh0384, 16'sh0032, 7, 16'h0001);
    reg_case(SLR_CTRL_VECTOR, 0, 1, 0, 16'sh01F4, 16'sh0032, 7, 16'h0000);
    reg_case(SLR_CTRL_VECTOR, 0, 0, 0, 16'sh0032, -16'sh0032, 2, 16'hFED4);
    fbk_rate = 16'h0001; // slow plant from here on
    reg_case(SLR_CTRL_VECTOR, 0, 0, 1, 16'sh00C8, 16'sh0032, 2, 16'h0000);
    $display("test schedule done");
    dev_case(SLR_DEV_DECEL, 1'b0, 1'b1);
    dev_case(SLR_DEV_COAST, 1'b0, 1'b1);
    dev_case(SLR_DEV_CONTINUE, 1'b0, 1'b1);
    dev_case(SLR_DEV_DECEL, 1'b1, 1'b0);
    $display("test deviation done");
    repeat (2) @(negedge clock);
    summarize();
  end
endmodule
`default_nettype wire
